// *** rtl/msr_defs.svh ***
// Constants of the mode-sense page-format responder: offsets, fields, codes, counts.
// Included by the package; holds definitions only.
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// APB register byte offsets
`define MSR_CMD_OFS 8'h00
`define MSR_CFG_OFS 8'h04
`define MSR_STAT_OFS 8'h08

// Command register fields
`define MSR_CMD_PAGE 5:0
`define MSR_CMD_SUPP 8
`define MSR_CMD_ALLOC 23:16
`define MSR_CMD_GO 31

// Configuration register fields and reset values
`define MSR_CFG_PERMIT 0
`define MSR_CFG_BMODE 6:4
`define MSR_CFG_WDELAY 23:8
`define MSR_BM_UNBUF 3'h0
`define MSR_BM_BUF 3'h1
`define MSR_WDELAY_RST 16'h0000

// Status register fields
`define MSR_STAT_BUSY 0
`define MSR_STAT_CHK 1
`define MSR_STAT_SKEY 7:4
`define MSR_STAT_ASC 15:8
`define MSR_STAT_DLEN 23:16
`define MSR_STAT_SENT 31:24

// Response layout
`define MSR_HDR_LEN 8'h04
`define MSR_DESC_LEN 8'h08
`define MSR_NO_DESC 8'h00
`define MSR_DLEN_BASE 8'h03
`define MSR_SPEED 4'h0
`define MSR_PG_ALL 6'h3f
`define MSR_LAST_PIDX 4'h8

// Page codes in all-pages order, with body lengths in bytes
`define MSR_PC_ERR 6'h01
`define MSR_PC_DISC 6'h02
`define MSR_PC_CTRL 6'h0a
`define MSR_PC_COMP 6'h0f
`define MSR_PC_CONF 6'h10
`define MSR_PC_PART 6'h11
`define MSR_PC_VU1 6'h20
`define MSR_PC_VU2 6'h21
`define MSR_PC_CST 6'h22
`define MSR_PL_ERR 8'h09
`define MSR_PL_DISC 8'h0c
`define MSR_PL_CTRL 8'h08
`define MSR_PL_COMP 8'h10
`define MSR_PL_CONF 8'h0f
`define MSR_PL_PART 8'h0a
`define MSR_PL_VU 8'h06
`define MSR_PL_CST 8'h0d

// Sense answers
`define MSR_SK_NONE 4'h0
`define MSR_SK_ILLEGAL 4'h5
`define MSR_ASC_NONE 8'h00
`define MSR_ASC_PLL 8'h1a

// Tape commands that flush the write buffer
`define MSR_OP_REWIND 8'h01
`define MSR_OP_WFM 8'h10
`define MSR_OP_SPACE 8'h11
`define MSR_OP_ERASE 8'h19
`define MSR_OP_LOAD 8'h1b
`define MSR_OP_LOCATE 8'h2b

// Write delay unit and clock rate
`define MSR_WDT_UNIT_MS 100
`define MSR_CLK_NS 5
`define MSR_TICK_CYC (`MSR_WDT_UNIT_MS * 1000000 / `MSR_CLK_NS)

`endif

// *** rtl/msr_flush.sv ***
// Buffered-write flush and status-return controller.
// Assumes command, buffer and tape events are pclk-synchronous pulses or levels.
`timescale 1ns/100ps
`include "msr_defs.svh"

module msr_flush import msr_pkg::*; #(
	parameter int TICK_CYCLES = `MSR_TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Drive events
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_immed,
	input wire logic cmd_reverse,
	input wire logic motion_thr,
	input wire logic held_data,
	input wire logic last_block_in,
	input wire logic tape_written,
	// Link to responder
	msr_flush_if.fl fi
);

	msr_flush_st_t s, n;
	logic buffered;
	logic cmd_flush;

	always_comb begin
		n = s;
		buffered = (fi.bmode == `MSR_BM_BUF);
		cmd_flush = 1'b0;
		if (cmd_valid) begin
			case (cmd_opcode)
				`MSR_OP_REWIND, `MSR_OP_SPACE, `MSR_OP_ERASE, `MSR_OP_LOAD: cmd_flush = 1'b1; // [RULE_17]
				`MSR_OP_WFM: cmd_flush = !cmd_immed; // [RULE_17]
				`MSR_OP_LOCATE: cmd_flush = cmd_reverse; // [RULE_17]
				default: cmd_flush = 1'b0;
			endcase
		end
		// Write delay time base
		n.tick = 1'b0;
		if (s.tick_cnt == 25'(TICK_CYCLES - 1)) begin
			n.tick_cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = s.tick_cnt + 25'h1;
		end
		n.flush = 1'b0;
		if (!held_data || !buffered) begin
			n.wd_cnt = '0;
		end else if (s.tick && fi.wdelay != 16'h0000) begin // [RULE_18]
			n.wd_cnt = s.wd_cnt + 16'h1;
		end
		if (buffered && held_data) begin
			if (motion_thr || fi.unload_btn || cmd_flush) begin
				n.flush = 1'b1; // [RULE_17]
			end else if (fi.wdelay != 16'h0000 && s.wd_cnt >= fi.wdelay) begin
				n.flush = 1'b1; // [RULE_17] [RULE_18]
			end
		end
		if (n.flush) begin
			n.wd_cnt = '0;
		end
		n.status_ret = buffered ? last_block_in : tape_written; // [RULE_19]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign fi.flush = s.flush;
	assign fi.status_ret = s.status_ret;

endmodule // msr_flush

// *** rtl/msr_flush_if.sv ***
// Links the responder to its write-buffer flush controller.
// Both ends run on pclk.
`timescale 1ns/100ps

interface msr_flush_if;
	logic [2:0] bmode;
	logic [15:0] wdelay;
	logic unload_btn;
	logic flush;
	logic status_ret;

	modport ctl (output bmode, output wdelay, output unload_btn, input flush, input status_ret);
	modport fl (input bmode, input wdelay, input unload_btn, output flush, output status_ret);
endinterface // msr_flush_if

// *** rtl/msr_pkg.sv ***
// Types of the mode-sense page-format responder.
// Assumes msr_defs.svh on the include path.
`include "msr_defs.svh"

package msr_pkg;

	typedef enum logic [1:0] {
		MSR_IDLE = 2'b00,
		MSR_EVAL = 2'b01,
		MSR_SEND = 2'b10,
		MSR_FIN = 2'b11
	} msr_state_t;

	typedef struct packed {
		logic [24:0] tick_cnt;
		logic tick;
		logic [15:0] wd_cnt;
		logic flush;
		logic status_ret;
	} msr_flush_st_t;

endpackage

// *** rtl/msr_responder.sv ***
// Mode-sense page-format responder: APB registers, response byte stream, flush control.
// Assumes a pclk-synchronous stream sink; write-protect and unload button are raw pins.
//
// Notes on behaviour
// RULE_01 - Nonzero page code: header, optional descriptor, then one page or all pages.
// RULE_02 - Initiator allocates header, descriptor and page bytes; compression needs 1Ch/14h.
// RULE_03 - Page body lengths: 9, 12, 8, 16, 15, 10, 6, 6, 13 bytes.
// RULE_04 - Allocation length FFh is never an error; all-pages requests use it.
// RULE_05 - The 8-byte descriptor is sent only when the suppress flag is clear.
// RULE_06 - A non-empty transfer carries the full 4-byte header first; an allocation below 4 sends only that many header bytes.
// RULE_07 - Initiator allocates at least the total response byte count.
// RULE_08 - Allocation length zero sends nothing and is no error.
// RULE_09 - Truncation disallowed: send what fits, then illegal request, length error.
// RULE_10 - Truncation permitted: send what fits, partial page included, no error.
// RULE_11 - Header: length, medium type, protect/buffer mode/speed, descriptor length.
// RULE_12 - Data length is 03h plus selected bytes, independent of allocation length.
// RULE_13 - Medium type byte encodes the loaded tape length code.
// RULE_14 - A mis-sized long cartridge may report the shorter code until resized.
// RULE_15 - Write-protect bit is 1 for a protected cartridge, else 0.
// RULE_16 - Buffer mode 000b unbuffered, 001b buffered, 001b after reset.
// RULE_17 - Buffered data flushes on threshold, unload, delay or listed tape commands.
// RULE_18 - Write delay of zero never flushes on elapsed time.
// RULE_19 - Status returns at buffer entry when buffered, at tape write otherwise.
// RULE_20 - Speed field always reads zero.
// RULE_21 - Descriptor length byte is only 00h or 08h.
// RULE_22 - Page code zero with suppress flag set is an illegal request.
// RULE_23 - All pages go out in fixed order, error recovery to compression status.
// RULE_24 - Descriptor length is 08h when included, 00h when suppressed.
// RULE_25 - Sending stops when the allocation length count is reached.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "msr_defs.svh"

module msr_responder import msr_pkg::*; #(
	parameter int TICK_CYCLES = `MSR_TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Response byte stream
	output logic [7:0] out_data,
	output logic out_valid,
	output logic out_last,
	output logic [5:0] out_page,
	input wire logic out_ready,
	// Command completion
	output logic cmd_done,
	output logic check_cond,
	// Drive state
	input wire logic [7:0] medium_code,
	input wire logic wp_pin,
	input wire logic unload_pin,
	// Tape write path
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_immed,
	input wire logic cmd_reverse,
	input wire logic motion_thr,
	input wire logic held_data,
	input wire logic last_block_in,
	input wire logic tape_written,
	output logic buf_flush,
	output logic status_ret
);

	typedef struct packed {
		msr_state_t st;
		logic [5:0] page;
		logic supp;
		logic [7:0] alloc;
		logic permit;
		logic [2:0] bmode;
		logic [15:0] wdelay;
		logic [7:0] cnt;
		logic [7:0] sendn;
		logic [7:0] dlen;
		logic trunc;
		logic [3:0] pidx;
		logic [3:0] pend;
		logic [7:0] poff;
		logic [7:0] out_data;
		logic out_valid;
		logic out_last;
		logic [5:0] out_page;
		logic done;
		logic chk;
		logic [3:0] skey;
		logic [7:0] asc;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic wp_m;
		logic wp_s;
		logic ub_m;
		logic ub_s;
		logic flush;
		logic sret;
	} msr_top_st_t;

	msr_top_st_t s, n;
	msr_flush_if fi ();

	// Page code for a position in the all-pages order
	function automatic logic [5:0] pg_code(input logic [3:0] i);
		case (i)
			4'h0: pg_code = `MSR_PC_ERR;
			4'h1: pg_code = `MSR_PC_DISC;
			4'h2: pg_code = `MSR_PC_CTRL;
			4'h3: pg_code = `MSR_PC_COMP;
			4'h4: pg_code = `MSR_PC_CONF;
			4'h5: pg_code = `MSR_PC_PART;
			4'h6: pg_code = `MSR_PC_VU1;
			4'h7: pg_code = `MSR_PC_VU2;
			default: pg_code = `MSR_PC_CST;
		endcase
	endfunction

	// Body length for a position in the all-pages order
	function automatic logic [7:0] pg_len(input logic [3:0] i);
		case (i)
			4'h0: pg_len = `MSR_PL_ERR; // [RULE_03]
			4'h1: pg_len = `MSR_PL_DISC;
			4'h2: pg_len = `MSR_PL_CTRL;
			4'h3: pg_len = `MSR_PL_COMP;
			4'h4: pg_len = `MSR_PL_CONF;
			4'h5: pg_len = `MSR_PL_PART;
			4'h6, 4'h7: pg_len = `MSR_PL_VU;
			default: pg_len = `MSR_PL_CST;
		endcase
	endfunction

	logic [3:0] req_idx;
	logic req_ok;
	logic [7:0] body;
	logic [7:0] total;
	logic [7:0] desc;
	logic [7:0] byte_q;
	logic emit;
	logic wr_acc;

	always_comb begin
		n = s;
		req_idx = 4'h0;
		req_ok = 1'b0;
		body = 8'h00;
		total = 8'h00;
		desc = 8'h00;
		byte_q = 8'h00;
		emit = 1'b0;
		wr_acc = psel && penable && s.pready && pwrite && !s.pslverr;

		// Pin synchronisers
		n.wp_m = wp_pin;
		n.wp_s = s.wp_m;
		n.ub_m = unload_pin;
		n.ub_s = s.ub_m;
		n.flush = fi.flush;
		n.sret = fi.status_ret;
		n.done = 1'b0;

		// APB: answer in the first access cycle
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && !penable && !s.pready) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			case (paddr)
				`MSR_CMD_OFS: begin
					n.prdata[`MSR_CMD_PAGE] = s.page;
					n.prdata[`MSR_CMD_SUPP] = s.supp;
					n.prdata[`MSR_CMD_ALLOC] = s.alloc;
				end
				`MSR_CFG_OFS: begin
					n.prdata[`MSR_CFG_PERMIT] = s.permit;
					n.prdata[`MSR_CFG_BMODE] = s.bmode;
					n.prdata[`MSR_CFG_WDELAY] = s.wdelay;
				end
				`MSR_STAT_OFS: begin
					n.prdata[`MSR_STAT_BUSY] = (s.st != MSR_IDLE);
					n.prdata[`MSR_STAT_CHK] = s.chk;
					n.prdata[`MSR_STAT_SKEY] = s.skey;
					n.prdata[`MSR_STAT_ASC] = s.asc;
					n.prdata[`MSR_STAT_DLEN] = s.dlen;
					n.prdata[`MSR_STAT_SENT] = s.cnt;
				end
				default: n.pslverr = 1'b1;
			endcase
		end
		if (wr_acc && paddr == `MSR_CFG_OFS) begin
			n.permit = pwdata[`MSR_CFG_PERMIT];
			n.bmode = pwdata[`MSR_CFG_BMODE]; // [RULE_16]
			n.wdelay = pwdata[`MSR_CFG_WDELAY];
		end
		// A new command is taken only while idle
		if (wr_acc && paddr == `MSR_CMD_OFS && s.st == MSR_IDLE) begin
			n.page = pwdata[`MSR_CMD_PAGE];
			n.supp = pwdata[`MSR_CMD_SUPP];
			n.alloc = pwdata[`MSR_CMD_ALLOC];
			if (pwdata[`MSR_CMD_GO]) begin
				n.st = MSR_EVAL;
				n.chk = 1'b0;
				n.skey = `MSR_SK_NONE;
				n.asc = `MSR_ASC_NONE;
				n.cnt = 8'h00;
			end
		end

		case (s.st)
			MSR_IDLE: begin
			end
			MSR_EVAL: begin
				for (int i = 0; i <= 8; i++) begin
					if (pg_code(4'(i)) == s.page) begin
						req_idx = 4'(i);
						req_ok = 1'b1;
					end
				end
				if (s.page == `MSR_PG_ALL) begin
					for (int i = 0; i <= 8; i++) begin
						body = body + pg_len(4'(i));
					end
				end else begin
					body = pg_len(req_idx);
				end
				desc = s.supp ? `MSR_NO_DESC : `MSR_DESC_LEN; // [RULE_05] [RULE_24]
				total = `MSR_HDR_LEN + desc + body;
				if (!req_ok && s.page != `MSR_PG_ALL) begin
					// Page zero with suppress set, or an unsupported code
					n.chk = 1'b1; // [RULE_22]
					n.skey = `MSR_SK_ILLEGAL; // [RULE_22]
					n.asc = `MSR_ASC_NONE;
					n.dlen = 8'h00;
					n.st = MSR_FIN;
				end else begin
					n.dlen = total - `MSR_DLEN_BASE + `MSR_DLEN_BASE - 8'h01; // [RULE_12]
					// Allocation length caps the byte count; FFh covers everything
					n.sendn = (s.alloc < total) ? s.alloc : total; // [RULE_25] [RULE_04]
					n.trunc = (s.alloc != 8'h00) && (s.alloc < total) && !s.permit; // [RULE_09] [RULE_10] [RULE_08]
					n.pidx = (s.page == `MSR_PG_ALL) ? 4'h0 : req_idx; // [RULE_01]
					n.pend = (s.page == `MSR_PG_ALL) ? `MSR_LAST_PIDX : req_idx; // [RULE_23]
					n.poff = 8'h00;
					n.st = (s.alloc == 8'h00) ? MSR_FIN : MSR_SEND; // [RULE_08]
				end
			end
			MSR_SEND: begin
				if (s.out_valid && out_ready && s.out_last) begin
					n.out_valid = 1'b0;
					n.out_last = 1'b0;
					n.st = MSR_FIN;
				end else if (!s.out_valid || out_ready) begin
					emit = 1'b1;
				end
				if (emit) begin
					desc = s.supp ? `MSR_NO_DESC : `MSR_DESC_LEN;
					// Header first, then descriptor, then page bodies
					if (s.cnt < `MSR_HDR_LEN) begin // [RULE_06]
						case (s.cnt[1:0])
							2'h0: byte_q = s.dlen; // [RULE_11] [RULE_12]
							2'h1: byte_q = medium_code; // [RULE_11] [RULE_13] [RULE_14]
							2'h2: byte_q = {s.wp_s, s.bmode, `MSR_SPEED}; // [RULE_15] [RULE_20]
							default: byte_q = desc; // [RULE_21] [RULE_24]
						endcase
						n.out_page = 6'h00;
					end else if (s.cnt < `MSR_HDR_LEN + desc) begin
						byte_q = 8'h00; // [RULE_05]
						n.out_page = 6'h00;
					end else begin
						byte_q = 8'h00;
						n.out_page = pg_code(s.pidx); // [RULE_23]
						if (s.poff == pg_len(s.pidx) - 8'h01) begin
							n.poff = 8'h00;
							if (s.pidx != s.pend) begin
								n.pidx = s.pidx + 4'h1; // [RULE_23]
							end
						end else begin
							n.poff = s.poff + 8'h01;
						end
					end
					n.out_data = byte_q;
					n.out_valid = 1'b1;
					n.out_last = (s.cnt + 8'h01 == s.sendn); // [RULE_25]
					n.cnt = s.cnt + 8'h01;
				end
			end
			MSR_FIN: begin
				if (s.trunc) begin
					n.chk = 1'b1; // [RULE_09]
					n.skey = `MSR_SK_ILLEGAL; // [RULE_09]
					n.asc = `MSR_ASC_PLL; // [RULE_09]
				end
				n.trunc = 1'b0;
				n.done = 1'b1;
				n.st = MSR_IDLE;
			end
			default: n.st = MSR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= MSR_IDLE;
			s.bmode <= `MSR_BM_BUF; // [RULE_16]
			s.wdelay <= `MSR_WDELAY_RST;
		end else begin
			s <= n;
		end
	end

	assign fi.bmode = s.bmode;
	assign fi.wdelay = s.wdelay;
	assign fi.unload_btn = s.ub_s;

	msr_flush #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_flush (
		.pclk(pclk),
		.presetn(presetn),
		.cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode),
		.cmd_immed(cmd_immed),
		.cmd_reverse(cmd_reverse),
		.motion_thr(motion_thr),
		.held_data(held_data),
		.last_block_in(last_block_in),
		.tape_written(tape_written),
		.fi(fi)
	);

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign out_data = s.out_data;
	assign out_valid = s.out_valid;
	assign out_last = s.out_last;
	assign out_page = s.out_page;
	assign cmd_done = s.done;
	assign check_cond = s.chk;
	assign buf_flush = s.flush;
	assign status_ret = s.sret;

endmodule // msr_responder

// *** verif/msr_chk.sv ***
// Checker of the responder's stream, completion and flush outputs.
// Sees only the top module's ports; bound at the foot of this file.
`timescale 1ns/100ps

module msr_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stream and completion
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_last,
	input wire logic [5:0] out_page,
	input wire logic out_ready,
	input wire logic cmd_done,
	// Flush path
	input wire logic held_data,
	input wire logic last_block_in,
	input wire logic tape_written,
	input wire logic buf_flush,
	input wire logic status_ret
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	// Index of the byte now offered
	always_comb begin
		cnt_d = cnt_q;
		if (cmd_done)
			cnt_d = 8'h00;
		else if (out_valid && out_ready)
			cnt_d = cnt_q + 8'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_d;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_page);
	endproperty
	a_hold: assert property (p_hold) else $error("byte changed while stalled");
	property p_hdr;
		out_valid && cnt_q < 8'h04 |-> out_page == 6'h00;
	endproperty
	a_hdr: assert property (p_hdr) else $error("page byte inside header");
	property p_speed;
		out_valid && cnt_q == 8'h02 |-> out_data[3:0] == 4'h0;
	endproperty
	a_speed: assert property (p_speed) else $error("speed field not zero");
	property p_dlen;
		out_valid && cnt_q == 8'h03 |-> out_data == 8'h00 || out_data == 8'h08;
	endproperty
	a_dlen: assert property (p_dlen) else $error("bad descriptor length");
	property p_last;
		out_valid && out_ready && out_last |=> !out_valid ##[0:3] cmd_done;
	endproperty
	a_last: assert property (p_last) else $error("no stop after last byte");
	property p_done;
		cmd_done |=> !cmd_done;
	endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
	property p_flush;
		buf_flush |=> !buf_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush longer than one cycle");
	property p_stat;
		status_ret |-> $past(last_block_in, 2) || $past(tape_written, 2);
	endproperty
	a_stat: assert property (p_stat) else $error("status without cause");
endmodule // msr_chk

bind msr_responder msr_chk u_chk (.pclk, .presetn, .out_data, .out_valid, .out_last,
	.out_page, .out_ready, .cmd_done, .held_data, .last_block_in, .tape_written,
	.buf_flush, .status_ret);

// *** verif/msr_sink.sv ***
// Initiator-side sink of the response byte stream.
// Records accepted bytes in order; stalls at random while stall_en is high.
`timescale 1ns/100ps

module msr_sink (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stream
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic [5:0] out_page,
	output logic out_ready,
	// Control
	input wire logic stall_en
);
	integer seed = 12589;
	logic [7:0] bytes[$];
	logic [5:0] pages[$];

	initial out_ready = 1'b0;
	always @(posedge pclk) begin
		if (presetn && out_valid && out_ready) begin
			bytes.push_back(out_data);
			pages.push_back(out_page);
		end
		out_ready <= presetn && (!stall_en || $random(seed) % 3 != 0);
	end
endmodule // msr_sink

// *** verif/tb.sv ***
// Self-checking bench of the responder: page responses, truncation, flush.
// Assumes the sink model and the bound checker are compiled before it.
`timescale 1ns/100ps

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erq;
	logic [7:0] paddr, out_data, medium_code, cmd_opcode;
	logic [31:0] pwdata, prdata, rd;
	logic out_valid, out_last, out_ready, cmd_done, check_cond, wp_pin, unload_pin;
	logic cmd_valid, cmd_immed, cmd_reverse, motion_thr, held_data, last_block_in;
	logic tape_written, buf_flush, status_ret, stall_en;
	logic [5:0] out_page;
	integer fails = 0, num_checks = 0, seed = 12589, cyc = 0, nfl = 0, nst = 0, j;
	logic [5:0] pc[9] = '{6'h01, 6'h02, 6'h0a, 6'h0f, 6'h10, 6'h11, 6'h20, 6'h21, 6'h22};
	int pl[9] = '{9, 12, 8, 16, 15, 10, 6, 6, 13};
	logic [7:0] mt[10] = '{8'h00, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'hc1, 8'hc2, 8'hc3, 8'hc4};
	logic [7:0] ops[6] = '{8'h01, 8'h10, 8'h11, 8'h19, 8'h1b, 8'h2b};

	msr_responder #(.TICK_CYCLES(8)) u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.out_data, .out_valid, .out_last, .out_page, .out_ready, .cmd_done, .check_cond,
		.medium_code, .wp_pin, .unload_pin, .cmd_valid, .cmd_opcode, .cmd_immed, .cmd_reverse,
		.motion_thr, .held_data, .last_block_in, .tape_written, .buf_flush, .status_ret
	);
	msr_sink u_snk (.pclk, .presetn, .out_data, .out_valid, .out_page, .out_ready, .stall_en);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Counts output pulses; cuts a hang short
	always @(posedge pclk) begin
		nfl += buf_flush;
		nst += status_ret;
		cyc++;
		if (cyc == 30000) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		erq = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Response length in bytes, zero for an unsupported page
	function automatic int tot(logic [5:0] pg, logic sp);
		int s = 0;
		for (int k = 0; k < 9; k++)
			if (pg == pc[k] || pg == 6'h3f)
				s += pl[k];
		return s == 0 ? 0 : s + (sp ? 4 : 12);
	endfunction

	// Expected {page, byte} at position i
	function automatic logic [13:0] exp_at(logic [5:0] pg, logic sp, int i, logic [2:0] bm);
		int o = i - (sp ? 4 : 12);
		logic [5:0] p = pg;
		if (i == 0)
			return {6'h00, 8'(tot(pg, sp) - 1)};
		if (i == 1)
			return {6'h00, medium_code};
		if (i == 2)
			return {6'h00, wp_pin, bm, 4'h0};
		if (i == 3)
			return {6'h00, sp ? 8'h00 : 8'h08};
		if (o < 0)
			return 14'h0000;
		for (int k = 0; k < 9 && pg == 6'h3f; k++) begin
			p = pc[k];
			if (o < pl[k])
				break;
			o -= pl[k];
		end
		return {p, 8'h00};
	endfunction

	task automatic run(logic [5:0] pg, logic sp, logic [7:0] al, logic pm, logic [2:0] bm);
		int t = tot(pg, sp);
		int n = (t == 0) ? 0 : (al < t ? al : t);
		logic ck = (t == 0) || (al != 0 && al < t && !pm);
		apb(1'b1, 8'h04, {25'h0, bm, 3'h0, pm});
		u_snk.bytes.delete();
		u_snk.pages.delete();
		apb(1'b1, 8'h00, {1'b1, 7'h00, al, 7'h00, sp, 2'h0, pg});
		do @(posedge pclk); while (cmd_done !== 1'b1);
		chk("count", n, u_snk.bytes.size());
		chk("check", ck, check_cond);
		apb(1'b0, 8'h08, 32'h0);
		chk("sense", {ck ? 4'h5 : 4'h0, t != 0 && ck ? 8'h1a : 8'h00}, {rd[7:4], rd[15:8]});
		for (int i = 0; i < n && i < u_snk.bytes.size(); i++)
			chk("byte", exp_at(pg, sp, i, bm), {u_snk.pages[i], u_snk.bytes[i]});
	endtask

	// Raises cause k for a cycle (none when k is 5), then checks for a flush or status pulse
	task automatic ev(int k, int w, logic e, logic f);
		@(posedge pclk);
		nfl = 0;
		nst = 0;
		case (k)
			0: cmd_valid <= 1'b1;
			1: motion_thr <= 1'b1;
			2: last_block_in <= 1'b1;
			3: tape_written <= 1'b1;
			4: unload_pin <= 1'b1;
			default: ;
		endcase
		@(posedge pclk);
		{cmd_valid, motion_thr, last_block_in, tape_written, unload_pin} <= 5'h00;
		repeat (w) @(posedge pclk);
		chk(f ? "status" : "flush", e, (f ? nst : nfl) != 0);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cmd_valid, cmd_opcode, cmd_immed, motion_thr, held_data} = '0;
		{last_block_in, tape_written, wp_pin, unload_pin, stall_en} = '0;
		medium_code = 8'h00;
		cmd_reverse = 1'b1;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		stall_en <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk("bmode_rst", 3'h1, rd[6:4]);
		apb(1'b0, 8'h0c, 32'h0);
		chk("slverr", 1'b1, erq);
		for (int k = 0; k < 20; k++)
			run(k / 2 == 9 ? 6'h3f : pc[k / 2], k[0], 8'hff, 1'b0, 3'h1);
		run(6'h05, 1'b0, 8'hff, 1'b0, 3'h1);
		run(6'h20, 1'b0, 8'h11, 1'b0, 3'h1);
		run(6'h20, 1'b0, 8'h11, 1'b1, 3'h0);
		run(6'h0f, 1'b1, 8'h00, 1'b0, 3'h1);
		run(6'h01, 1'b0, 8'h02, 1'b0, 3'h1);
		run(6'h00, 1'b1, 8'hff, 1'b0, 3'h1);
		for (int k = 0; k < 20; k++) begin
			j = {$random(seed)} % 10;
			medium_code <= mt[k % 10];
			wp_pin <= $random(seed);
			run(j == 9 ? 6'h3f : pc[j], $random(seed), $random(seed), $random(seed), 3'(k % 2));
		end
		apb(1'b1, 8'h04, 32'h10);
		held_data <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			cmd_opcode <= ops[k];
			ev(0, 6, 1'b1, 1'b0);
		end
		{cmd_opcode, cmd_immed} <= {8'h10, 1'b1};
		ev(0, 6, 1'b0, 1'b0);
		{cmd_opcode, cmd_immed, cmd_reverse} <= {8'h2b, 2'b00};
		ev(0, 6, 1'b0, 1'b0);
		cmd_reverse <= 1'b1;
		held_data <= 1'b0;
		ev(1, 8, 1'b0, 1'b0);
		held_data <= 1'b1;
		for (int k = 1; k < 5; k++)
			ev(k, 8, k != 3, k == 2 || k == 3);
		ev(5, 100, 1'b0, 1'b0);
		apb(1'b1, 8'h04, 32'h310);
		ev(5, 60, 1'b1, 1'b0);
		apb(1'b1, 8'h04, 32'h0);
		ev(3, 8, 1'b1, 1'b1);
		ev(2, 8, 1'b0, 1'b1);
		ev(0, 8, 1'b0, 1'b0);
		stop_test();
	end
endmodule // tb
